// >>> src/ppid_map.svh
// Selector codes, field positions, reset values and timing counts of the process PID regulator.
`ifndef PPID_MAP_SVH
`define PPID_MAP_SVH

// ****************************************************************
// Timing.
// ****************************************************************
`define PPID_MCLK_PERIOD_NS   5
`define PPID_CTRL_PERIOD_NS   4000000
`define PPID_TICKS_PER_DSEC   32'sh0000_0019

// ****************************************************************
// Selector codes and field positions.
// ****************************************************************
`define PPID_CHAN_PID         8'h17
`define PPID_PRIO_PID         16'h0007
`define PPID_PRIO_RATED0      16'h0000
`define PPID_PRIO_RATED1      16'h0001
`define PPID_MODE_MSB         15
`define PPID_MODE_LSB         12
`define PPID_DEV_POL_BIT      0
`define PPID_OUT_POL_BIT      4

// ****************************************************************
// Scaling constants.
// ****************************************************************
`define PPID_FULL_PCT         32'sh0000_2710
`define PPID_VOLT_MAX         16'h03E8
`define PPID_CURR_MAX         16'h07D0
`define PPID_GAIN_DIV         32'sh0000_0064
`define PPID_PRESET_SCALE     32'sh0000_000A
`define PPID_BAND_SCALE       32'sh0000_000A
`define PPID_I_SCALE          32'sh0000_03E8
`define PPID_I_GAIN           32'sh0000_0190
`define PPID_DERIV_DIV        32'sh0000_0004
`define PPID_FILT_NUM         32'sh0000_0004
`define PPID_FILT_DEN         32'sh0000_000A

// ****************************************************************
// Reset values of the settings.
// ****************************************************************
`define PPID_SP_MAX_DEF       16'h03E8
`define PPID_FB_MAX_DEF       16'h01F4
`define PPID_MULT_DEF         16'h0064
`define PPID_KP_DEF           16'h00C8
`define PPID_TI_DEF           16'h00C8
`define PPID_TF_DEF           16'h03E8
`define PPID_BAND_DEF         16'h0032
`define PPID_SENSOR_FULL_DEF  16'h0064

`endif

// >>> src/ppid_pkg.sv
// Types and shared arithmetic of the process PID regulator.
package ppid_pkg;

  typedef logic signed [31:0] ppid_wide_t;

  typedef enum logic [2:0]
  {
    PPID_IDLE = 3'b001,
    PPID_HOLD = 3'b010,
    PPID_LOOP = 3'b100
  } ppid_hold_e;

  function automatic ppid_wide_t ppid_sat(input ppid_wide_t x, input ppid_wide_t lo,
                                          input ppid_wide_t hi);
    ppid_wide_t r;
    r = x;
    if (x < lo)
      r = lo;
    else if (x > hi)
      r = hi;
    return r;
  endfunction

  function automatic ppid_wide_t ppid_abs(input ppid_wide_t x);
    return (x < 0) ? -x : x;
  endfunction

  function automatic ppid_wide_t ppid_u2w(input logic [15:0] x);
    return ppid_wide_t'({16'h0000, x});
  endfunction

endpackage

// >>> src/ppid_scale.sv
// Linear mapping of an analog sample onto hundredths of a percent.
`timescale 1ns/1ps
`default_nettype none
`include "ppid_map.svh"

module ppid_scale
  import ppid_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Analog sample and mapping points.
  input  wire logic [15:0] ain,
  input  wire logic [15:0] pt_min,
  input  wire logic [15:0] pt_max,
  input  wire logic        current_analog_input,
  // Mapped value.
  output var  logic [15:0] pct
);

  logic [15:0] lim;
  logic [15:0] hi;
  logic [15:0] lo;
  ppid_wide_t  span_pct;

  always_comb
  begin
    lim = current_analog_input ? `PPID_CURR_MAX : `PPID_VOLT_MAX;
    hi  = (pt_max > lim) ? lim : pt_max;
    lo  = (pt_min > hi) ? hi : pt_min;
    span_pct = '0;
    if (ain <= lo)
      span_pct = '0;
    else if (ain >= hi)
      span_pct = `PPID_FULL_PCT;
    else
      span_pct = (ppid_u2w(ain - lo) * `PPID_FULL_PCT) / ppid_u2w(hi - lo);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pct <= '0;
    else if (ce)
      pct <= span_pct[15:0];
  end

  scale_clamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && ain >= hi) |=> (pct == 16'h2710))
    else $error("Input above the upper point did not map to full scale.");

endmodule
`default_nettype wire

// >>> src/ppid_hold.sv
// Start-up sequencer that holds the preset output before closed-loop regulation.
`timescale 1ns/1ps
`default_nettype none
`include "ppid_map.svh"

module ppid_hold
  import ppid_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Control period pulse and run command.
  input  wire logic        tick,
  input  wire logic        run_cmd,
  input  wire logic [15:0] preset_hold_time,
  // Sequencer state.
  output logic             holding,
  output logic             closed_loop
);

  ppid_hold_e state_r;
  logic [31:0] cnt_r;
  logic        run_prev_r;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r    <= PPID_IDLE;
      cnt_r      <= '0;
      run_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      run_prev_r <= run_cmd;
      case (state_r)
        PPID_IDLE:
          if (run_cmd && !run_prev_r)
          begin
            if (preset_hold_time == 16'h0000)
              state_r <= PPID_LOOP;
            else
            begin
              state_r <= PPID_HOLD;
              cnt_r   <= 32'(ppid_u2w(preset_hold_time) * `PPID_TICKS_PER_DSEC);
            end
          end
        PPID_HOLD:
          if (!run_cmd)
            state_r <= PPID_IDLE;
          else if (tick)
          begin
            if (cnt_r <= 32'h0000_0001)
              state_r <= PPID_LOOP;
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        PPID_LOOP:
          if (!run_cmd)
            state_r <= PPID_IDLE;
        default:
          state_r <= PPID_IDLE;
      endcase
    end
  end

  assign holding     = (state_r == PPID_HOLD);
  assign closed_loop = (state_r == PPID_LOOP);

  hold_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && run_cmd && holding && tick && cnt_r == 32'h0000_0001) |=> closed_loop)
    else $error("Hold did not release into closed loop after the hold time.");

endmodule
`default_nettype wire

// >>> src/ppid_top.sv
// Process PID regulator: scaling, PID terms, polarity, preset hold and command limit.
`timescale 1ns/1ps
`default_nettype none
`include "ppid_map.svh"


module ppid_top
  import ppid_pkg::*;
#(
  parameter int CTRL_PERIOD_CYC = `PPID_CTRL_PERIOD_NS / `PPID_MCLK_PERIOD_NS
)
(
  // Clock, reset and enable.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Run command.
  input  wire logic        run_cmd,
  input  wire logic        run_dir,
  // Selection and configuration.
  input  wire logic [15:0] pid_function_select,
  input  wire logic [7:0]  main_freq_channel_select,
  input  wire logic [7:0]  aux_freq_channel_select,
  input  wire logic [15:0] freq_reference_priority,
  input  wire logic [15:0] controller_config,
  input  wire logic        direction_lock,
  // Setpoint analog input.
  input  wire logic [15:0] sp_ain,
  input  wire logic        sp_ch_sel,
  input  wire logic        sp_current_analog_input,
  input  wire logic [15:0] setpoint_in_min_ch1,
  input  wire logic [15:0] setpoint_in_max_ch1,
  input  wire logic [15:0] setpoint_in_min_ch2,
  input  wire logic [15:0] setpoint_in_max_ch2,
  // Feedback analog input.
  input  wire logic [15:0] fb_ain,
  input  wire logic        fb_ch_sel,
  input  wire logic        fb_current_analog_input,
  input  wire logic [15:0] feedback_in_min_ch1,
  input  wire logic [15:0] feedback_in_max_ch1,
  input  wire logic [15:0] feedback_in_min_ch2,
  input  wire logic [15:0] feedback_in_max_ch2,
  input  wire logic [15:0] feedback_multiplier,
  // Tuning.
  input  wire logic [15:0] proportional_gain,
  input  wire logic [15:0] integral_time,
  input  wire logic [15:0] derivative_coefficient,
  input  wire logic [15:0] derivative_filter_time,
  input  wire logic [15:0] static_deviation_band,
  input  wire logic [15:0] output_preset,
  input  wire logic [15:0] preset_hold_time,
  // Frequency path.
  input  wire logic [15:0] upper_freq_limit,
  input  wire logic signed [15:0] superposition_freq,
  // Monitoring points.
  input  wire logic [15:0] sensor_value_at_full,
  input  wire logic signed [15:0] sensor_value_at_zero,
  // Command outputs.
  output var  logic [15:0] freq_cmd,
  output var  logic        freq_dir,
  output var  logic        pid_cmd_valid,
  output var  logic [15:0] cmd_upper_limit,
  output var  logic signed [15:0] pid_out,
  output var  logic        sleep_wake_enable,
  output logic             preset_holding,
  // Monitoring outputs.
  output var  logic signed [15:0] feedback_display_a,
  output var  logic signed [15:0] feedback_display_b
);

  // ****************************************************************
  // Control period.
  // ****************************************************************
  logic [31:0] per_cnt_r;
  logic        tick_r;
  logic        tick;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      per_cnt_r <= '0;
      tick_r    <= 1'b0;
    end
    else if (ce)
    begin
      if (per_cnt_r == 32'(CTRL_PERIOD_CYC - 1))
      begin
        per_cnt_r <= '0;
        tick_r    <= 1'b1;
      end
      else
      begin
        per_cnt_r <= per_cnt_r + 32'h0000_0001;
        tick_r    <= 1'b0;
      end
    end
  end

  assign tick = tick_r && ce;

  // ****************************************************************
  // Analog scaling and sequencing.
  // ****************************************************************
  logic [15:0] sp_pct;
  logic [15:0] fb_pct;
  logic        closed_loop;

  ppid_scale u_sp_scale (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .ce                   (ce),
    .ain                  (sp_ain),
    .pt_min               (sp_ch_sel ? setpoint_in_min_ch2 : setpoint_in_min_ch1),
    .pt_max               (sp_ch_sel ? setpoint_in_max_ch2 : setpoint_in_max_ch1),
    .current_analog_input (sp_current_analog_input),
    .pct                  (sp_pct)
  );

  ppid_scale u_fb_scale (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .ce                   (ce),
    .ain                  (fb_ain),
    .pt_min               (fb_ch_sel ? feedback_in_min_ch2 : feedback_in_min_ch1),
    .pt_max               (fb_ch_sel ? feedback_in_max_ch2 : feedback_in_max_ch1),
    .current_analog_input (fb_current_analog_input),
    .pct                  (fb_pct)
  );

  ppid_hold u_hold (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .ce               (ce),
    .tick             (tick),
    .run_cmd          (run_cmd),
    .preset_hold_time (preset_hold_time),
    .holding          (preset_holding),
    .closed_loop      (closed_loop)
  );

  // ****************************************************************
  // Regulator terms.
  // ****************************************************************
  ppid_wide_t i_acc_r;
  ppid_wide_t e_prev_r;
  ppid_wide_t d_f_r;
  ppid_wide_t fb_mul;
  ppid_wide_t dev;
  ppid_wide_t p_term;
  ppid_wide_t i_next;
  ppid_wide_t d_raw;
  ppid_wide_t d_next;
  ppid_wide_t u_sum;
  ppid_wide_t u_lo;
  ppid_wide_t tf;
  ppid_wide_t preset_pct;
  logic       dual;
  logic       in_band;

  always_comb
  begin
    dual   = controller_config[`PPID_OUT_POL_BIT];
    fb_mul = ppid_sat((ppid_u2w(fb_pct) * ppid_u2w(feedback_multiplier)) / `PPID_GAIN_DIV,
                      '0, `PPID_FULL_PCT);
    dev    = controller_config[`PPID_DEV_POL_BIT] ? (fb_mul - ppid_u2w(sp_pct))
                                                 : (ppid_u2w(sp_pct) - fb_mul);
    in_band = ppid_abs(dev) <= ppid_u2w(static_deviation_band) * `PPID_BAND_SCALE;
    p_term = ppid_sat((dev * ppid_u2w(proportional_gain)) / `PPID_GAIN_DIV,
                      -`PPID_FULL_PCT, `PPID_FULL_PCT);
    i_next = '0;
    if (integral_time != 16'h0000)
      i_next = ppid_sat(i_acc_r + (dev * `PPID_I_GAIN) / ppid_u2w(integral_time),
                        -`PPID_FULL_PCT * `PPID_I_SCALE,
                        `PPID_FULL_PCT * `PPID_I_SCALE);
    d_raw  = ppid_sat((ppid_u2w(derivative_coefficient) * (dev - e_prev_r)) / `PPID_DERIV_DIV,
                      -`PPID_FULL_PCT, `PPID_FULL_PCT);
    tf     = (derivative_filter_time == 16'h0000) ? 32'sh0000_0001
                                                  : ppid_u2w(derivative_filter_time);
    d_next = d_f_r + ((d_raw - d_f_r) * `PPID_FILT_NUM) / (tf * `PPID_FILT_DEN);
    u_lo   = dual ? -`PPID_FULL_PCT : 32'sh0000_0000;
    u_sum  = ppid_sat(p_term + i_next / `PPID_I_SCALE + d_next, u_lo, `PPID_FULL_PCT);
    preset_pct = ppid_u2w(output_preset) * `PPID_PRESET_SCALE;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      i_acc_r  <= '0;
      e_prev_r <= '0;
      d_f_r    <= '0;
      pid_out  <= '0;
    end
    else if (tick)
    begin
      if (!run_cmd)
      begin
        i_acc_r  <= '0;
        e_prev_r <= '0;
        d_f_r    <= '0;
        pid_out  <= '0;
      end
      else if (preset_holding)
      begin
        i_acc_r  <= preset_pct * `PPID_I_SCALE;
        e_prev_r <= dev;
        d_f_r    <= '0;
        pid_out  <= 16'(preset_pct);
      end
      else if (derivative_coefficient == 16'h0000)
      begin
        d_f_r <= '0;
        if (!in_band && closed_loop)
        begin
          i_acc_r  <= i_next;
          e_prev_r <= dev;
          pid_out  <= 16'(ppid_sat(p_term + i_next / `PPID_I_SCALE, u_lo, `PPID_FULL_PCT));
        end
      end
      else if (!in_band && closed_loop)
      begin
        i_acc_r  <= i_next;
        e_prev_r <= dev;
        d_f_r    <= d_next;
        pid_out  <= 16'(u_sum);
      end
    end
  end

  // ****************************************************************
  // Frequency command, limit and direction.
  // ****************************************************************
  logic       pid_sel;
  logic       rated_prio;
  logic       sup_neg;
  ppid_wide_t sup_mag;
  ppid_wide_t out_mag;
  ppid_wide_t hz;
  ppid_wide_t lim;

  always_comb
  begin
    pid_sel = ((main_freq_channel_select == `PPID_CHAN_PID) ||
               (aux_freq_channel_select == `PPID_CHAN_PID)) &&
              (freq_reference_priority == `PPID_PRIO_PID);
    rated_prio = (freq_reference_priority == `PPID_PRIO_RATED0) ||
                 (freq_reference_priority == `PPID_PRIO_RATED1);
    sup_neg = superposition_freq[15];
    sup_mag = ppid_abs(ppid_wide_t'(superposition_freq));
    out_mag = ppid_abs(ppid_wide_t'(pid_out));
    hz      = (out_mag * ppid_u2w(upper_freq_limit)) / `PPID_FULL_PCT;
    case (pid_function_select[`PPID_MODE_MSB:`PPID_MODE_LSB])
      4'h1:    lim = sup_mag;
      4'h2:    lim = (pid_out[15] == sup_neg)
                     ? ppid_sat(ppid_u2w(upper_freq_limit) - sup_mag, '0, 32'sh0000_FFFF)
                     : sup_mag;
      default: lim = ppid_u2w(upper_freq_limit);
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      freq_cmd          <= '0;
      freq_dir          <= 1'b0;
      pid_cmd_valid     <= 1'b0;
      cmd_upper_limit   <= '0;
      sleep_wake_enable <= 1'b0;
    end
    else if (ce)
    begin
      pid_cmd_valid     <= pid_sel;
      cmd_upper_limit   <= lim[15:0];
      sleep_wake_enable <= !pid_sel && rated_prio;
      freq_cmd          <= pid_sel ? ((hz > lim) ? lim[15:0] : hz[15:0]) : 16'h0000;
      freq_dir          <= (dual && !direction_lock) ? (run_dir ^ pid_out[15]) : run_dir;
    end
  end

  // ****************************************************************
  // Monitoring.
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      feedback_display_a <= '0;
      feedback_display_b <= '0;
    end
    else if (ce)
    begin
      feedback_display_a <= 16'(ppid_wide_t'(sensor_value_at_zero) +
                            (ppid_u2w(fb_pct) * ppid_u2w(sensor_value_at_full)) /
                            `PPID_FULL_PCT);
      feedback_display_b <= 16'(ppid_wide_t'(sensor_value_at_zero) +
                            (ppid_u2w(sp_pct) * ppid_u2w(sensor_value_at_full)) /
                            `PPID_FULL_PCT);
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  period_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && tick_r) |-> (per_cnt_r == 32'h0000_0000))
    else $error("Control period pulse not aligned to counter wrap.");

  cmd_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !pid_sel) |=> (freq_cmd == 16'h0000 && !pid_cmd_valid))
    else $error("Frequency command driven while PID not selected.");

  limit_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> (freq_cmd <= $past(lim[15:0])))
    else $error("Frequency command above the selected upper limit.");

  sleep_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && (pid_sel || !rated_prio)) |=> !sleep_wake_enable)
    else $error("Sleep enabled in superposition or wrong priority.");

  single_pol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && !dual) |=> (pid_out >= 0))
    else $error("Single polarity output went negative.");

  dir_xor_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && dual && !direction_lock) |=> (freq_dir == ($past(run_dir) ^ $past(pid_out[15]))))
    else $error("Dual polarity direction is not run direction XOR sign.");

  band_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && run_cmd && !preset_holding && in_band) |=> $stable(i_acc_r) && $stable(pid_out))
    else $error("Regulator adjusted inside the static deviation band.");

  deriv_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && derivative_coefficient == 16'h0000) |=> (d_f_r == 0))
    else $error("Derivative term active with zero coefficient.");

  preset_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && run_cmd && preset_holding) |=> (pid_out == 16'($past(output_preset) * 16'h000A)))
    else $error("Held output differs from the preset.");

endmodule
`default_nettype wire

// >>> tb/ppid_far_model.sv
// Model of the analog inputs and the superposition channel that feed the regulator.
`timescale 1ns/1ps
`default_nettype none

module ppid_far_model
(
  // Clock.
  input  wire logic               mclk,
  // Levels requested by the bench.
  input  wire logic [15:0]        sp_set,
  input  wire logic [15:0]        fb_set,
  input  wire logic signed [15:0] sup_set,
  // Sampled analog values and superposition frequency.
  output var  logic [15:0]        sp_ain,
  output var  logic [15:0]        fb_ain,
  output var  logic signed [15:0] superposition_freq
);
  // The converters deliver a new sample one clock after the level settles.
  always_ff @(posedge mclk)
  begin
    sp_ain             <= sp_set;
    fb_ain             <= fb_set;
    superposition_freq <= sup_set;
  end
endmodule

`default_nettype wire

// >>> tb/tb_process_pid_controller.sv
// Self-checking bench of the process PID regulator.
`timescale 1ns/1ps
`default_nettype none

module tb_process_pid_controller;
  logic mclk = 0, rst_n = 0, run_cmd = 0, run_dir = 0, lock = 0, spsel = 1, spc = 0, fbc = 0;
  logic [7:0] chm = 8'h00, cha = 8'h05;
  logic [15:0] fsel = 16'h0000, prio = 16'h0000, cfg = 16'h0000, kp = 16'h0064, ti = 16'h0000;
  logic [15:0] kd = 16'h0000, tf = 16'h03E8, band = 16'h0032, pre = 16'h01F4, hold = 16'h0001;
  logic [15:0] upper = 16'h1388, mult = 16'h0064, full = 16'h0190, sp_set = 16'h0190;
  logic [15:0] fb_set = 16'h00FA, spmn = 16'h00C8, spmx = 16'h0258, fbmx = 16'h03E8;
  logic signed [15:0] zero = -16'sh0032, sup_set = 16'sh03E8, sup, pid, da, db;
  logic [15:0] sp_ain, fb_ain, fcmd, lim;
  logic fdir, valid, swe, holding;
  logic ce = 1, fbsel = 0;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [15:0] lim_x [4] = '{16'h1388, 16'h03E8, 16'h0FA0, 16'h03E8};
  logic [15:0] fc_x [4] = '{16'h09C4, 16'h03E8, 16'h09C4, 16'h03E8};

  always #2.5 mclk = ~mclk;

  ppid_far_model far (.mclk(mclk), .sp_set(sp_set), .fb_set(fb_set), .sup_set(sup_set),
    .sp_ain(sp_ain), .fb_ain(fb_ain), .superposition_freq(sup));

  ppid_top #(.CTRL_PERIOD_CYC(20)) dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .run_cmd(run_cmd), .run_dir(run_dir), .pid_function_select(fsel),
    .main_freq_channel_select(chm), .aux_freq_channel_select(cha),
    .freq_reference_priority(prio), .controller_config(cfg), .direction_lock(lock),
    .sp_ain(sp_ain), .sp_ch_sel(spsel), .sp_current_analog_input(spc),
    .setpoint_in_min_ch1(16'h0000), .setpoint_in_max_ch1(16'h03E8),
    .setpoint_in_min_ch2(spmn), .setpoint_in_max_ch2(spmx), .fb_ain(fb_ain),
    .fb_ch_sel(fbsel), .fb_current_analog_input(fbc), .feedback_in_min_ch1(16'h0000),
    .feedback_in_max_ch1(fbmx), .feedback_in_min_ch2(16'h0000),
    .feedback_in_max_ch2(16'h03E8), .feedback_multiplier(mult), .proportional_gain(kp),
    .integral_time(ti), .derivative_coefficient(kd), .derivative_filter_time(tf),
    .static_deviation_band(band), .output_preset(pre), .preset_hold_time(hold),
    .upper_freq_limit(upper), .superposition_freq(sup), .sensor_value_at_full(full),
    .sensor_value_at_zero(zero), .freq_cmd(fcmd), .freq_dir(fdir), .pid_cmd_valid(valid),
    .cmd_upper_limit(lim), .pid_out(pid), .sleep_wake_enable(swe),
    .preset_holding(holding), .feedback_display_a(da), .feedback_display_b(db));

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    w(3);
    rst_n = 1;
    w(1);
    chk("pid_out", 16'h0000, pid);
    chk("freq_cmd", 16'h0000, fcmd);
    $display("test reset done");
    chm = 8'h17;
    prio = 16'h0001;
    w(3);
    chk("valid", 16'h0000, {15'h0000, valid});
    chk("sleep", 16'h0001, {15'h0000, swe});
    prio = 16'h0007;
    w(3);
    chk("valid", 16'h0001, {15'h0000, valid});
    chk("sleep", 16'h0000, {15'h0000, swe});
    $display("test select done");
    run_cmd = 1;
    w(45);
    chk("holding", 16'h0001, {15'h0000, holding});
    chk("pid_out", 16'h1388, pid);
    for (int i = 0; i < 4; i++)
    begin
      fsel = (i == 3) ? 16'h2000 : {i[3:0], 12'h000};
      sup_set = (i == 3) ? -16'sh03E8 : 16'sh03E8;
      w(4);
      chk("limit", lim_x[i], lim);
      chk("freq_cmd", fc_x[i], fcmd);
    end
    fsel = 16'h0000;
    $display("test preset done");
    w(500);
    chk("holding", 16'h0000, {15'h0000, holding});
    chk("pid_out", 16'h09C4, pid);
    chk("freq_cmd", 16'h04E2, fcmd);
    chk("disp_a", 16'h0032, da);
    chk("disp_b", 16'h0096, db);
    mult = 16'h00C8;
    w(45);
    chk("pid_band", 16'h09C4, pid);
    mult = 16'h012C;
    w(45);
    chk("pid_single", 16'h0000, pid);
    cfg = 16'h0001;
    w(45);
    chk("pid_neg_dev", 16'h09C4, pid);
    cfg = 16'h0010;
    w(45);
    chk("pid_dual", -16'sh09C4, pid);
    chk("dir", 16'h0001, {15'h0000, fdir});
    chk("freq_cmd", 16'h04E2, fcmd);
    lock = 1;
    w(3);
    chk("dir_lock", 16'h0000, {15'h0000, fdir});
    chk("freq_lock", 16'h04E2, fcmd);
    mult = 16'h0064;
    fb_set = 16'h07D0;
    w(45);
    chk("pid_clamp", -16'sh1388, pid);
    $display("test loop done");
    fbmx = 16'h07D0;
    fbc = 1;
    fb_set = 16'h03E8;
    w(4);
    chk("disp_cur", 16'h0096, da);
    fbsel = 1;
    w(4);
    chk("disp_ch2", 16'h015E, da);
    spsel = 0;
    w(4);
    chk("disp_sp1", 16'h006E, db);
    ce = 0;
    fb_set = 16'h0000;
    w(4);
    chk("disp_frozen", 16'h015E, da);
    ce = 1;
    w(4);
    chk("disp_zero", 16'hFFCE, da);
    $display("test scaling done");
    run_cmd = 0;
    w(45);
    chk("pid_stop", 16'h0000, pid);
    $display("test stop done");
    cfg = 16'h0000;
    kp = 16'h0000;
    ti = 16'h0001;
    hold = 16'h0000;
    run_cmd = 1;
    while (pid == 16'h0000)
      w(1);
    chk("pid_int1", 16'h0640, pid);
    w(20);
    chk("pid_int2", 16'h0C80, pid);
    w(100);
    chk("pid_int_sat", 16'h2710, pid);
    $display("test integral done");
    run_cmd = 0;
    ti = 16'h0000;
    kd = 16'h0004;
    tf = 16'h0001;
    w(25);
    chk("pid_stop2", 16'h0000, pid);
    run_cmd = 1;
    while (pid == 16'h0000)
      w(1);
    chk("pid_d1", 16'h0640, pid);
    w(20);
    chk("pid_d2", 16'h03C0, pid);
    w(20);
    chk("pid_d3", 16'h0240, pid);
    $display("test derivative done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
